/* File: core/dmss_dev_end.sv */
// dmss_dev_end: slave end of the dual protocol serial bus.
// assumes: host drives clock and strobe; register storage lives
// outside and answers rd_addr_o combinationally on rd_data_i.
//
// Functional notes
// - slave only; never drives clock
// - fixed address e4 write, e5 read
// - one clock per bit, msb first
// - both lines idle high between transfers
// - falling strobe selects spi framing
// - no acknowledge in spi mode
// - spi frame: dead bits, three bytes
// - host holds clock high after 27th rise
// - host lowers strobe after clock fall
// - early data fall restarts as i2c
// - spi samples data on clock rise
// - spi write commits on 26th rise
// - strobe high early discards spi frame
// - spi output changes on clock fall
// - first two spi bits ignored
// - spi read turns line after register
// - strobe high means i2c slave
// - i2c ack low after each byte it receives when addressed
// - host nack ends read, line released
`timescale 1ns/1ps
module dmss_dev_end (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // serial bus
  dmss_bus_if.dev         bus,
  // register write port
  output logic            wr_en_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  // register read port
  output logic [7:0]      rd_addr_o,
  input  wire logic [7:0] rd_data_i,
  // status
  output logic            spi_mode_o
);
  // ----------------------------------------
  // input sampling and edges
  // ----------------------------------------
  logic scl_s;
  logic sda_s;
  logic stb_s;
  logic scl_d_ff;
  logic sda_d_ff;
  logic stb_d_ff;

  dmss_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({bus.scl, bus.sda, bus.strobe}),
    .sync_o    ({scl_s, sda_s, stb_s})
  );

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      stb_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      stb_d_ff <= stb_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic stb_fall;
  logic stb_rise;
  logic sda_fall_hi;
  logic sda_rise_hi;

  assign scl_rise    = scl_s & ~scl_d_ff;
  assign scl_fall    = ~scl_s & scl_d_ff;
  assign stb_fall    = ~stb_s & stb_d_ff;
  assign stb_rise    = stb_s & ~stb_d_ff;
  assign sda_fall_hi = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign sda_rise_hi = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ----------------------------------------
  // protocol state
  // ----------------------------------------
  dmss_pkg::dmss_dev_state_type state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] ptr_ff, nxt_ptr;
  logic       ack_ff, nxt_ack;
  logic       match_ff, nxt_match;
  logic       rnw_ff, nxt_rnw;
  logic       oe_ff, nxt_oe;
  logic       wr_en_ff, nxt_wr_en;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [7:0] wr_data_ff, nxt_wr_data;
  logic [7:0] sh_in;
  logic [4:0] cnt_up;
  logic       start_seen;
  logic       stop_seen;

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_sh      = sh_ff;
    nxt_tx      = tx_ff;
    nxt_ptr     = ptr_ff;
    nxt_ack     = ack_ff;
    nxt_match   = match_ff;
    nxt_rnw     = rnw_ff;
    nxt_oe      = oe_ff;
    nxt_wr_en   = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    sh_in  = {sh_ff[6:0], sda_s};
    cnt_up = (cnt_ff == dmss_pkg::CNT_MAX) ? cnt_ff : 5'(cnt_ff + 5'h01);
    start_seen = sda_fall_hi & (stb_s | (state_ff == dmss_pkg::DV_SPI && cnt_ff == 5'h00));
    stop_seen  = sda_rise_hi & stb_s;

    if (stb_fall)
    begin
      nxt_state = dmss_pkg::DV_SPI;
      nxt_cnt   = 5'h00;
      nxt_oe    = 1'b0;
      nxt_match = 1'b0;
      nxt_rnw   = 1'b0;
      nxt_ack   = 1'b0;
    end
    else if (stb_rise)
    begin
      nxt_state = dmss_pkg::DV_IDLE;
      nxt_oe    = 1'b0;
    end
    else if (start_seen)
    begin
      nxt_state = dmss_pkg::DV_ADDR;
      nxt_cnt   = 5'h00;
      nxt_oe    = 1'b0;
      nxt_ack   = 1'b0;
    end
    else if (stop_seen)
    begin
      nxt_state = dmss_pkg::DV_IDLE;
      nxt_oe    = 1'b0;
    end
    else if (state_ff == dmss_pkg::DV_SPI)
    begin
      if (scl_rise)
      begin
        nxt_sh  = sh_in;
        nxt_cnt = cnt_up;
        if (cnt_up == dmss_pkg::SPI_ADDR_END)
        begin
          nxt_match = (sh_in[7:1] == dmss_pkg::SLAVE_ADDR_WR[7:1]);
          nxt_rnw   = sh_in[0];
        end
        if (cnt_up == dmss_pkg::SPI_REG_END)
          nxt_ptr = sh_in;
        if (cnt_up == dmss_pkg::SPI_DATA_END && match_ff && !rnw_ff)
        begin
          nxt_wr_en   = 1'b1;
          nxt_wr_addr = ptr_ff;
          nxt_wr_data = sh_in;
        end
      end
      if (scl_fall)
      begin
        if (match_ff && rnw_ff && cnt_ff >= dmss_pkg::SPI_REG_END
            && cnt_ff < dmss_pkg::SPI_DATA_END)
        begin
          if (cnt_ff == dmss_pkg::SPI_REG_END)
          begin
            nxt_tx = rd_data_i;
            nxt_oe = ~rd_data_i[7];
          end
          else
            nxt_oe = ~tx_ff[3'(dmss_pkg::SPI_DATA_END - 5'h01 - cnt_ff)];
        end
        else
          nxt_oe = 1'b0;
      end
    end
    else if (state_ff != dmss_pkg::DV_IDLE && state_ff != dmss_pkg::DV_IGN)
    begin
      if (scl_rise)
      begin
        if (cnt_ff < dmss_pkg::BYTE_CNT)
        begin
          nxt_sh  = sh_in;
          nxt_cnt = cnt_up;
          if (cnt_up == dmss_pkg::BYTE_CNT)
          begin
            case (state_ff)
              dmss_pkg::DV_ADDR:
              begin
                if (sh_in[7:1] == dmss_pkg::SLAVE_ADDR_WR[7:1])
                begin
                  nxt_ack   = 1'b1;
                  nxt_state = sh_in[0] ? dmss_pkg::DV_RD : dmss_pkg::DV_REG;
                end
                else
                  nxt_state = dmss_pkg::DV_IGN;
              end
              dmss_pkg::DV_REG:
              begin
                nxt_ptr   = sh_in;
                nxt_ack   = 1'b1;
                nxt_state = dmss_pkg::DV_WR;
              end
              dmss_pkg::DV_WR:
              begin
                nxt_wr_en   = 1'b1;
                nxt_wr_addr = ptr_ff;
                nxt_wr_data = sh_in;
                nxt_ptr     = 8'(ptr_ff + 8'h01);
                nxt_ack     = 1'b1;
              end
              default:
                nxt_ack = 1'b0;
            endcase
          end
        end
        else
        begin
          nxt_cnt = 5'h00;
          if (state_ff == dmss_pkg::DV_RD && !ack_ff)
          begin
            if (sda_s)
              nxt_state = dmss_pkg::DV_IGN;
            else
              nxt_ptr = 8'(ptr_ff + 8'h01);
          end
        end
      end
      if (scl_fall)
      begin
        if (cnt_ff == dmss_pkg::BYTE_CNT && ack_ff)
          nxt_oe = 1'b1;
        else if (state_ff == dmss_pkg::DV_RD && cnt_ff < dmss_pkg::BYTE_CNT)
        begin
          if (cnt_ff == 5'h00)
          begin
            nxt_tx = rd_data_i;
            nxt_oe = ~rd_data_i[7];
          end
          else
            nxt_oe = ~tx_ff[3'(3'h7 - cnt_ff[2:0])];
        end
        else
          nxt_oe = 1'b0;
        if (cnt_ff == 5'h00)
          nxt_ack = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_ff   <= dmss_pkg::DV_IDLE;
      cnt_ff     <= 5'h00;
      sh_ff      <= 8'h00;
      tx_ff      <= 8'h00;
      ptr_ff     <= 8'h00;
      ack_ff     <= 1'b0;
      match_ff   <= 1'b0;
      rnw_ff     <= 1'b0;
      oe_ff      <= 1'b0;
      wr_en_ff   <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end
    else
    begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      sh_ff      <= nxt_sh;
      tx_ff      <= nxt_tx;
      ptr_ff     <= nxt_ptr;
      ack_ff     <= nxt_ack;
      match_ff   <= nxt_match;
      rnw_ff     <= nxt_rnw;
      oe_ff      <= nxt_oe;
      wr_en_ff   <= nxt_wr_en;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain data only, clock is an input
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = oe_ff;
  assign wr_en_o        = wr_en_ff;
  assign wr_addr_o      = wr_addr_ff;
  assign wr_data_o      = wr_data_ff;
  assign rd_addr_o      = ptr_ff;
  assign spi_mode_o     = (state_ff == dmss_pkg::DV_SPI);
endmodule

/* File: core/dmss_pkg.sv */
// dmss_pkg: constants and types shared by both ends of the
// dual protocol serial bus.
// assumes: 40 MHz system clock on both ends.
package dmss_pkg;

  // ----------------------------------------
  // addressing
  // ----------------------------------------
  localparam logic [7:0] SLAVE_ADDR_WR = 8'he4;
  localparam logic [7:0] SLAVE_ADDR_RD = 8'he5;

  // ----------------------------------------
  // frame counts (rising edges of the serial clock)
  // ----------------------------------------
  localparam logic [4:0] BYTE_CNT      = 5'h08;
  localparam logic [4:0] CNT_MAX       = 5'h1f;
  localparam logic [4:0] SPI_DEAD_BITS = 5'h02;
  localparam logic [4:0] SPI_ADDR_END  = SPI_DEAD_BITS + BYTE_CNT;
  localparam logic [4:0] SPI_REG_END   = SPI_ADDR_END + BYTE_CNT;
  localparam logic [4:0] SPI_DATA_END  = SPI_REG_END + BYTE_CNT;
  localparam int         SPI_STROBE_MAX_CLK = 35;

  // ----------------------------------------
  // host slot indices
  // ----------------------------------------
  localparam logic [5:0] I2C_SLOT_BITS = 6'h09;
  localparam logic [5:0] I2C_RD_RSTART = 6'h13;
  localparam logic [5:0] I2C_WR_STOP   = 6'h1c;
  localparam logic [5:0] I2C_RD_STOP   = 6'h26;
  localparam logic [5:0] SPI_FIN_SLOT  = 6'h1b;
  localparam logic [5:0] SPI_DEAD_END  = 6'h02;
  localparam logic [5:0] SPI_ADDR_SLOT = 6'h0a;
  localparam logic [5:0] SPI_REG_SLOT  = 6'h12;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int NS_PER_S      = 1000000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int QUARTERS      = 4;
  localparam int I2C_MAX_BPS   = 400000;
  localparam int SPI_MAX_BPS   = 2000000;
  localparam int I2C_QTR_CYC   = (NS_PER_S / I2C_MAX_BPS + QUARTERS * CLK_PERIOD_NS - 1)
                                 / (QUARTERS * CLK_PERIOD_NS);
  localparam int SPI_QTR_CYC   = (NS_PER_S / SPI_MAX_BPS + QUARTERS * CLK_PERIOD_NS - 1)
                                 / (QUARTERS * CLK_PERIOD_NS);

  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [2:0] {DV_IDLE, DV_ADDR, DV_REG, DV_WR, DV_RD, DV_IGN, DV_SPI}
    dmss_dev_state_type;
  typedef enum logic {HS_IDLE, HS_RUN} dmss_host_state_type;
  typedef enum logic [2:0] {SL_START, SL_BIT, SL_STOP, SL_PRE, SL_FIN} dmss_slot_type;

endpackage

/* File: core/dmss_bus_if.sv */
// dmss_bus_if: the three bus wires between host and slave.
// assumes: data line is open drain with a pull-up; the line
// level is resolved here from both output enables.
`timescale 1ns/1ps
interface dmss_bus_if;
  logic scl;
  logic strobe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic sda;

  // pulled high unless some end drives it low
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport dev (input scl, input strobe, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output strobe, input sda, output host_sda_o,
                output host_sda_oe);
endinterface

/* File: core/dmss_sync.sv */
// dmss_sync: two flip-flop synchroniser, one lane per bit.
// assumes: inputs are asynchronous levels.
`timescale 1ns/1ps
module dmss_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // idle bus level is high, so reset to ones
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      meta_ff <= '1;
      sync_ff <= '1;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule

/* File: core/dmss_host_end.sv */
// dmss_host_end: bus master end; runs one i2c or spi transfer
// per go_i pulse.
// assumes: go_i only while busy_o is low; slave at fixed address.
`timescale 1ns/1ps
module dmss_host_end #(
  parameter int I2C_QTR = dmss_pkg::I2C_QTR_CYC,
  parameter int SPI_QTR = dmss_pkg::SPI_QTR_CYC
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // serial bus
  dmss_bus_if.host        bus,
  // request
  input  wire logic       go_i,
  input  wire logic       spi_i,
  input  wire logic       rnw_i,
  input  wire logic [7:0] reg_i,
  input  wire logic [7:0] data_i,
  // answer
  output logic            busy_o,
  output logic            done_o,
  output logic            nack_o,
  output logic [7:0]      rdata_o
);
  logic sda_s;

  dmss_sync #(
    .WIDTH (1)
  ) u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (bus.sda),
    .sync_o    (sda_s)
  );

  // ----------------------------------------
  // slot decode
  // ----------------------------------------
  dmss_pkg::dmss_host_state_type hst_ff, nxt_hst;
  dmss_pkg::dmss_slot_type kind;
  logic [5:0]  idx_ff, nxt_idx;
  logic [1:0]  q_ff, nxt_q;
  logic [15:0] qc_ff, nxt_qc;
  logic        spi_ff, nxt_spi;
  logic        rnw_ff, nxt_rnw;
  logic [7:0]  reg_ff, nxt_reg;
  logic [7:0]  data_ff, nxt_data;
  logic        scl_ff, nxt_scl;
  logic        stb_ff, nxt_stb;
  logic        oe_ff, nxt_oe;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        nack_ff, nxt_nack;
  logic        done_ff, nxt_done;
  logic        bitv, rx, ackchk, last, tick;
  logic [5:0]  r, bn, k;
  logic [7:0]  byte_v;

  always_comb
  begin
    kind   = dmss_pkg::SL_BIT;
    bitv   = 1'b1;
    rx     = 1'b0;
    ackchk = 1'b0;
    last   = 1'b0;
    r      = 6'h00;
    bn     = 6'h00;
    k      = 6'h00;
    byte_v = 8'hff;
    if (spi_ff)
    begin
      // pre slot, dead bits, three bytes, final rise
      if (idx_ff == 6'h00)
        kind = dmss_pkg::SL_PRE;
      else if (idx_ff == dmss_pkg::SPI_FIN_SLOT)
      begin
        kind = dmss_pkg::SL_FIN;
        last = 1'b1;
      end
      else if (idx_ff > dmss_pkg::SPI_REG_SLOT)
      begin
        bitv = rnw_ff ? 1'b1 : data_ff[3'(dmss_pkg::SPI_FIN_SLOT - 6'h01 - idx_ff)];
        rx   = rnw_ff;
      end
      else if (idx_ff > dmss_pkg::SPI_ADDR_SLOT)
        bitv = reg_ff[3'(dmss_pkg::SPI_REG_SLOT - idx_ff)];
      else if (idx_ff > dmss_pkg::SPI_DEAD_END)
      begin
        byte_v = rnw_ff ? dmss_pkg::SLAVE_ADDR_RD : dmss_pkg::SLAVE_ADDR_WR;
        bitv   = byte_v[3'(dmss_pkg::SPI_ADDR_SLOT - idx_ff)];
      end
    end
    else
    begin
      if (idx_ff == 6'h00 || (rnw_ff && idx_ff == dmss_pkg::I2C_RD_RSTART))
        kind = dmss_pkg::SL_START;
      else if (idx_ff == (rnw_ff ? dmss_pkg::I2C_RD_STOP : dmss_pkg::I2C_WR_STOP))
      begin
        kind = dmss_pkg::SL_STOP;
        last = 1'b1;
      end
      else
      begin
        r  = (rnw_ff && idx_ff > dmss_pkg::I2C_RD_RSTART) ?
             6'(idx_ff - dmss_pkg::I2C_RD_RSTART - 6'h01) : 6'(idx_ff - 6'h01);
        bn = 6'(r / dmss_pkg::I2C_SLOT_BITS);
        k  = 6'(r % dmss_pkg::I2C_SLOT_BITS);
        if (rnw_ff && idx_ff > dmss_pkg::I2C_RD_RSTART)
          byte_v = (bn == 6'h00) ? dmss_pkg::SLAVE_ADDR_RD : 8'hff;
        else
          byte_v = (bn == 6'h00) ? dmss_pkg::SLAVE_ADDR_WR : (bn == 6'h01) ? reg_ff : data_ff;
        // last read byte gets no ack
        if (k == 6'h08)
          ackchk = !(rnw_ff && idx_ff > dmss_pkg::I2C_RD_RSTART && bn == 6'h01);
        else
        begin
          bitv = byte_v[3'(3'h7 - k[2:0])];
          rx   = rnw_ff && idx_ff > dmss_pkg::I2C_RD_RSTART && bn == 6'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign tick = (qc_ff == 16'((spi_ff ? SPI_QTR : I2C_QTR) - 1));

  always_comb
  begin
    nxt_hst   = hst_ff;
    nxt_idx   = idx_ff;
    nxt_q     = q_ff;
    nxt_qc    = qc_ff;
    nxt_spi   = spi_ff;
    nxt_rnw   = rnw_ff;
    nxt_reg   = reg_ff;
    nxt_data  = data_ff;
    nxt_rdata = rdata_ff;
    nxt_nack  = nack_ff;
    nxt_done  = 1'b0;
    nxt_scl   = 1'b1;
    nxt_stb   = 1'b1;
    nxt_oe    = 1'b0;
    case (hst_ff)
      dmss_pkg::HS_IDLE:
      begin
        if (go_i)
        begin
          nxt_hst  = dmss_pkg::HS_RUN;
          nxt_idx  = 6'h00;
          nxt_q    = 2'h0;
          nxt_qc   = 16'h0000;
          nxt_spi  = spi_i;
          nxt_rnw  = rnw_i;
          nxt_reg  = reg_i;
          nxt_data = data_i;
          nxt_nack = 1'b0;
        end
      end
      default:
      begin
        nxt_qc = tick ? 16'h0000 : 16'(qc_ff + 16'h0001);
        if (tick)
        begin
          nxt_q = 2'(q_ff + 2'h1);
          // sample at end of clock high
          if (q_ff == 2'h2 && rx)
            nxt_rdata = {rdata_ff[6:0], sda_s};
          if (q_ff == 2'h2 && ackchk && sda_s)
            nxt_nack = 1'b1;
          if (q_ff == 2'h3)
          begin
            if (last)
            begin
              nxt_hst  = dmss_pkg::HS_IDLE;
              nxt_done = 1'b1;
            end
            else
              nxt_idx = 6'(idx_ff + 6'h01);
          end
        end
        case (kind)
          dmss_pkg::SL_START:
          begin
            nxt_scl = (q_ff == 2'h1 || q_ff == 2'h2);
            nxt_oe  = q_ff[1];
          end
          dmss_pkg::SL_STOP:
          begin
            nxt_scl = (q_ff != 2'h0);
            nxt_oe  = ~q_ff[1];
          end
          dmss_pkg::SL_PRE:
          begin
            nxt_scl = 1'b0;
            nxt_stb = ~q_ff[1];
          end
          // clock held high at the end
          dmss_pkg::SL_FIN:
          begin
            nxt_stb = q_ff[1];
          end
          default:
          begin
            // data moves only while clock low
            nxt_scl = (q_ff == 2'h1 || q_ff == 2'h2);
            nxt_oe  = ~bitv;
            nxt_stb = ~spi_ff;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      hst_ff   <= dmss_pkg::HS_IDLE;
      idx_ff   <= 6'h00;
      q_ff     <= 2'h0;
      qc_ff    <= 16'h0000;
      spi_ff   <= 1'b0;
      rnw_ff   <= 1'b0;
      reg_ff   <= 8'h00;
      data_ff  <= 8'h00;
      scl_ff   <= 1'b1;
      stb_ff   <= 1'b1;
      oe_ff    <= 1'b0;
      rdata_ff <= 8'h00;
      nack_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end
    else
    begin
      hst_ff   <= nxt_hst;
      idx_ff   <= nxt_idx;
      q_ff     <= nxt_q;
      qc_ff    <= nxt_qc;
      spi_ff   <= nxt_spi;
      rnw_ff   <= nxt_rnw;
      reg_ff   <= nxt_reg;
      data_ff  <= nxt_data;
      scl_ff   <= nxt_scl;
      stb_ff   <= nxt_stb;
      oe_ff    <= nxt_oe;
      rdata_ff <= nxt_rdata;
      nack_ff  <= nxt_nack;
      done_ff  <= nxt_done;
    end
  end

  assign bus.scl         = scl_ff;
  assign bus.strobe      = stb_ff;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = oe_ff;
  assign busy_o          = (hst_ff == dmss_pkg::HS_RUN);
  assign done_o          = done_ff;
  assign nack_o          = nack_ff;
  assign rdata_o         = rdata_ff;
endmodule

/* File: test/dmss_assertions.sv */
// dmss_assertions: wire-level checks on the shared bus.
// assumes: host quarter of 4 clock_i cycles.
`timescale 1ns/1ps
module dmss_assertions (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // bus wires
  input wire logic scl,
  input wire logic strobe,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  // ----------------------------------------
  // rise count and shifted bits of a frame
  // ----------------------------------------
  logic       scl_ff;
  logic       nxt_scl;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  always_comb
  begin
    nxt_scl = sys_rst_i | scl;
    nxt_cnt = (sys_rst_i | strobe) ? 5'h00 : cnt_ff + {4'h0, scl & ~scl_ff};
    nxt_sh  = (scl & ~scl_ff) ? {sh_ff[6:0], sda} : sh_ff;
  end
  always_ff @(posedge clock_i)
  begin
    scl_ff <= nxt_scl;
    cnt_ff <= nxt_cnt;
    sh_ff  <= nxt_sh;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*4])
    else $error("clock high phase too short");
  AST_STROBE_AFTER_FALL: assert property ($fell(strobe) |-> !scl)
    else $error("strobe fell with clock high");
  AST_FRAME_LEN: assert property (!strobe |-> cnt_ff <= 5'h1b)
    else $error("frame longer than 27 rises");
  AST_CLK_HELD: assert property (!strobe && cnt_ff == 5'h1b |-> scl)
    else $error("clock dropped after last rise");
  AST_DEAD_HIGH: assert property (!strobe && cnt_ff < 5'h02 |-> sda)
    else $error("data moved in dead bits");
  AST_ADDR: assert property (!strobe && cnt_ff == 5'h0a
    |-> sh_ff[7:1] == dmss_pkg::SLAVE_ADDR_WR[7:1])
    else $error("wrong slave address in frame");
  AST_NO_SPI_ACK: assert property (!strobe && dev_sda_oe |-> cnt_ff >= 5'h12)
    else $error("slave drove before register byte");
  // slave moves three edges after the clock pin falls, so three samples back
  AST_OUT_ON_FALL: assert property (!strobe && $changed(dev_sda_oe)
    |-> !$past(scl, 3))
    else $error("slave output moved off clock fall");
  AST_RELEASE_END: assert property ($rose(strobe) |-> ##6 !dev_sda_oe)
    else $error("slave kept line after frame");
endmodule

/* File: test/tb.sv */
// tb: both bus ends joined, register file kept here.
// assumes: both quarters shortened to 4 clocks.
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       go = 1'b0;
  logic       spi = 1'b0;
  logic       rnw = 1'b0;
  logic [7:0] reg_a = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       done;
  logic       nack;
  logic       busy;
  logic       spi_mode;
  logic       hung = 1'b0;
  logic       wr_en;
  logic [7:0] rdata;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] mem [256];
  int         failures = 0;
  int         check_count = 0;
  int         seed = 36;
  int         wr_seen = 0;
  dmss_bus_if bus ();
  dmss_dev_end dmss_dev_end_inst (.clock_i, .sys_rst_i, .bus(bus.dev),
    .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rd_addr_o(rd_addr), .rd_data_i(mem[rd_addr]), .spi_mode_o(spi_mode));
  dmss_host_end #(.I2C_QTR(4), .SPI_QTR(4)) dmss_host_end_inst (.clock_i,
    .sys_rst_i, .bus(bus.host), .go_i(go), .spi_i(spi), .rnw_i(rnw),
    .reg_i(reg_a), .data_i(wdata), .busy_o(busy), .done_o(done), .nack_o(nack),
    .rdata_o(rdata));
  dmss_assertions dmss_assertions_inst (.clock_i, .sys_rst_i, .scl(bus.scl),
    .strobe(bus.strobe), .sda(bus.sda), .dev_sda_oe(bus.dev_sda_oe));
  initial forever #12.5 clock_i = ~clock_i;
  // register file fed by the slave write port
  always_ff @(posedge clock_i)
    if (wr_en === 1'b1)
    begin
      mem[wr_addr] <= wr_data;
      wr_seen <= wr_seen + 1;
    end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // register writes one request must commit
  function automatic logic [7:0] writes_for(input logic r);
    return r ? 8'h00 : 8'h01;
  endfunction
  // one request; bounded wait on done
  task automatic xfer(input logic s, input logic r, input logic [7:0] a,
                      input logic [7:0] d);
    int   n;
    logic saw_spi;
    n = 0;
    saw_spi = 1'b0;
    @(posedge clock_i);
    go <= 1'b1;
    spi <= s;
    rnw <= r;
    reg_a <= a;
    wdata <= d;
    @(posedge clock_i);
    go <= 1'b0;
    #1;
    check({7'h00, busy}, 8'h01);
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clock_i);
      #1;
      n++;
      if (spi_mode === 1'b1)
        saw_spi = 1'b1;
    end
    // a hang stops the sequence and fails the run
    if (n == 3000)
    begin
      failures++;
      hung = 1'b1;
    end
    check({7'h00, nack}, 8'h00);
    check({7'h00, saw_spi}, {7'h00, s});
    check({6'h00, busy, spi_mode}, 8'h00);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] a;
    logic [7:0] d;
    int         w;
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    // corners first: all-zero and all-one bytes
    for (int i = 0; i < 16 && !hung; i++)
    begin
      a = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      d = (i < 2) ? ~a : 8'($random(seed));
      w = wr_seen;
      xfer(i[1], 1'b0, a, d);
      check(8'(wr_seen - w), writes_for(1'b0));
      check(mem[a], d);
      w = wr_seen;
      xfer(i[1] ^ i[0], 1'b1, a, 8'h00);
      check(rdata, d);
      check(8'(wr_seen - w), writes_for(1'b1));
    end
    wrap_up();
  end
endmodule
